/* src/can_tx_buffer_message_store.sv */
// Transmit buffer message store with error tally and window mapping
//
// Our own choices: the plain strobed port and the address map.
`default_nettype none
module can_tx_buffer_message_store #(
  parameter int NUM_BUF = 3,
  parameter int NUM_DATA = 8
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire txbuf_pkg::reg_req_t    bus_in,
  output logic     [7:0]              rdata_out,
  // Bit engine side
  output logic                        tx_start_out,
  output txbuf_pkg::frame_t           tx_frame_out,
  output logic     [1:0]              tx_buf_out,
  input  wire logic                   tx_done_in,
  input  wire logic                   tx_err_in,
  input  wire logic                   tx_ok_in,
  input  wire logic                   recessive_bit_in,
  output logic                        bus_off_out,
  output logic                        irq_out
);
  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] con_q  [NUM_BUF];
  logic [7:0] sidh_q [NUM_BUF];
  logic [7:0] sidl_q [NUM_BUF];
  logic [7:0] eidh_q [NUM_BUF];
  logic [7:0] eidl_q [NUM_BUF];
  logic [7:0] len_q  [NUM_BUF];
  logic [7:0] data_q [NUM_BUF][NUM_DATA];
  logic [7:0] ctrl_q;
  logic [7:0] tally_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic       bus_off_q;
  logic       busy_q;
  logic [1:0] cur_q;
  logic [3:0] run_q;
  logic [7:0] runs_q;
  logic [7:0] rdata_q;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  wire       window_on = ctrl_q[3:0] == txbuf_pkg::WINDOW_BUF0;
  wire [3:0] page     = bus_in.addr[7:4];
  wire [3:0] ofs      = bus_in.addr[3:0];
  wire       rx0_hit  = page == txbuf_pkg::PAGE_RX_ZERO[7:4];
  wire       buf_hit  = (page < txbuf_pkg::PAGE_RX_ZERO[7:4]) || (rx0_hit && window_on);
  wire [1:0] sel      = rx0_hit ? 2'h0 : page[1:0];
  wire       is_data  = ofs >= txbuf_pkg::OFS_DATA0;
  wire [2:0] didx     = ofs[2:0];
  wire       locked   = con_q[sel][txbuf_pkg::BIT_REQ];
  wire       wr_buf   = bus_in.wr && buf_hit;
  wire       wr_body  = wr_buf && !locked;
  wire       mode_ok  = ctrl_q[7:5] == txbuf_pkg::MODE_NORMAL ||
                        ctrl_q[7:5] == txbuf_pkg::MODE_LOOP;
  wire       clr_stat = bus_in.wr && bus_in.addr == txbuf_pkg::ADDR_STAT;

  // Lowest pending buffer wins; priority bits kept for software only
  logic       pend;
  logic [1:0] pick;
  always_comb begin
    pend = 1'b0;
    pick = 2'h0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (con_q[i][txbuf_pkg::BIT_REQ]) begin
        pend = 1'b1;
        pick = 2'(i);
      end
    end
  end
  wire start = pend && !busy_q && mode_ok && !bus_off_q;

  // ---------------------------------------------------------------------------
  // Frame assembly
  // ---------------------------------------------------------------------------
  wire        ext   = sidl_q[cur_q][txbuf_pkg::BIT_EXT_EN];
  wire [10:0] sid   = {sidh_q[cur_q], sidl_q[cur_q][7:5]};
  wire [28:0] ident = ext ? {sid, sidl_q[cur_q][1:0], eidh_q[cur_q], eidl_q[cur_q]}
                          : {18'h00000, sid};
  wire [3:0]  dl    = len_q[cur_q][3:0] > txbuf_pkg::LEN_MAX ?
                      txbuf_pkg::LEN_MAX : len_q[cur_q][3:0];
  logic [63:0] dflat;
  always_comb begin
    dflat = 64'h0;
    for (int m = 0; m < NUM_DATA; m++) dflat[m*8 +: 8] = data_q[cur_q][m];
  end

  // ---------------------------------------------------------------------------
  // Register writes and sequencing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        con_q[i]  <= txbuf_pkg::ZERO8;
        sidh_q[i] <= txbuf_pkg::ZERO8;
        sidl_q[i] <= txbuf_pkg::ZERO8;
        eidh_q[i] <= txbuf_pkg::ZERO8;
        eidl_q[i] <= txbuf_pkg::ZERO8;
        len_q[i]  <= txbuf_pkg::ZERO8;
        for (int m = 0; m < NUM_DATA; m++) data_q[i][m] <= txbuf_pkg::ZERO8;
      end
      ctrl_q       <= txbuf_pkg::ZERO8;
      busy_q       <= 1'b0;
      cur_q        <= 2'h0;
      tx_start_out <= 1'b0;
    end else begin
      tx_start_out <= start;
      if (start) begin
        busy_q <= 1'b1;
        cur_q  <= pick;
      end
      if (busy_q && tx_done_in) begin
        busy_q <= 1'b0;
        if (tx_ok_in) con_q[cur_q][txbuf_pkg::BIT_REQ] <= 1'b0;
      end
      if (bus_in.wr && bus_in.addr == txbuf_pkg::ADDR_CTRL) ctrl_q <= bus_in.wdata;
      if (wr_buf && ofs == txbuf_pkg::OFS_CON && !(busy_q && tx_done_in && cur_q == sel))
        con_q[sel] <= bus_in.wdata & txbuf_pkg::CON_WMASK;
      if (wr_body) begin
        unique case (ofs)
          txbuf_pkg::OFS_SIDH: sidh_q[sel] <= bus_in.wdata;
          txbuf_pkg::OFS_SIDL: sidl_q[sel] <= bus_in.wdata & txbuf_pkg::SIDL_WMASK;
          txbuf_pkg::OFS_EIDH: eidh_q[sel] <= bus_in.wdata;
          txbuf_pkg::OFS_EIDL: eidl_q[sel] <= bus_in.wdata;
          txbuf_pkg::OFS_LEN:  len_q[sel]  <= bus_in.wdata & txbuf_pkg::LEN_WMASK;
          default: if (is_data) data_q[sel][didx] <= bus_in.wdata;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Error tally, bus-off and recovery
  // ---------------------------------------------------------------------------
  wire run_done = recessive_bit_in && run_q == 4'(txbuf_pkg::RUN_BITS - 1);
  wire recovered = bus_off_q && run_done && runs_q == 8'(txbuf_pkg::RUN_COUNT - 1);
  wire tally_ovf = tx_err_in && tally_q == 8'hFF;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tally_q   <= txbuf_pkg::ZERO8;
      bus_off_q <= 1'b0;
      run_q     <= 4'h0;
      runs_q    <= txbuf_pkg::ZERO8;
    end else begin
      run_q <= (!recessive_bit_in || run_done) ? 4'h0 : run_q + 4'h1;
      if (recovered) begin
        tally_q   <= txbuf_pkg::ZERO8;
        bus_off_q <= 1'b0;
        runs_q    <= txbuf_pkg::ZERO8;
      end else begin
        if (bus_off_q && run_done) runs_q <= runs_q + 8'h01;
        if (tally_ovf) bus_off_q <= 1'b1;
        if (tx_err_in && !bus_off_q) tally_q <= tally_q + 8'h01;
        else if (tx_ok_in && tx_done_in && tally_q != txbuf_pkg::ZERO8 && !bus_off_q)
          tally_q <= tally_q - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts: sent, error, bus-off; set wins over clear
  // ---------------------------------------------------------------------------
  wire [2:0] ev = {tally_ovf, tx_err_in, busy_q && tx_done_in && tx_ok_in};
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stat_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~(clr_stat ? bus_in.wdata[2:0] : 3'h0)) | ev;
      if (bus_in.wr && bus_in.addr == txbuf_pkg::ADDR_MASK) mask_q <= bus_in.wdata[2:0];
    end
  end
  assign irq_out = |(stat_q & mask_q);

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    rmux = txbuf_pkg::ZERO8;
    if (buf_hit) begin
      unique case (ofs)
        txbuf_pkg::OFS_CON:  rmux = con_q[sel];
        txbuf_pkg::OFS_SIDH: rmux = sidh_q[sel];
        txbuf_pkg::OFS_SIDL: rmux = sidl_q[sel];
        txbuf_pkg::OFS_EIDH: rmux = eidh_q[sel];
        txbuf_pkg::OFS_EIDL: rmux = eidl_q[sel];
        txbuf_pkg::OFS_LEN:  rmux = len_q[sel];
        default:             rmux = is_data ? data_q[sel][didx] : txbuf_pkg::ZERO8;
      endcase
    end else begin
      unique case (bus_in.addr)
        txbuf_pkg::ADDR_CTRL: rmux = ctrl_q;
        txbuf_pkg::ADDR_TALLY: rmux = tally_q;
        txbuf_pkg::ADDR_STAT: rmux = {5'h00, stat_q};
        txbuf_pkg::ADDR_MASK: rmux = {5'h00, mask_q};
        default:              rmux = txbuf_pkg::ZERO8;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) rdata_q <= txbuf_pkg::ZERO8;
    else if (bus_in.rd) rdata_q <= rmux;
    else rdata_q <= txbuf_pkg::ZERO8;
  end
  assign rdata_out = rdata_q;
  assign bus_off_out = bus_off_q;
  assign tx_buf_out = cur_q;
  assign tx_frame_out = '{extended: ext, ident: ident,
                          remote: len_q[cur_q][txbuf_pkg::BIT_RTR],
                          length: dl, data: dflat};

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_no_bus_off_start: assert property (@(posedge clk_in) disable iff (reset_in)
    bus_off_q |=> !tx_start_out) else $error("start while bus-off");
  chk_mode_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_start_out |-> $past(mode_ok)) else $error("start outside normal or loopback");
  chk_one_frame: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_start_out |=> !tx_start_out) else $error("second start while sending");
  chk_len_clamp: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_frame_out.length <= txbuf_pkg::LEN_MAX) else $error("length beyond eight");
  chk_std_ident: assert property (@(posedge clk_in) disable iff (reset_in)
    !tx_frame_out.extended |-> tx_frame_out.ident[28:11] == 18'h0)
    else $error("ext bytes in std frame");
  chk_ovf_bus_off: assert property (@(posedge clk_in) disable iff (reset_in)
    tally_ovf |=> bus_off_q) else $error("overflow missed bus-off");
  chk_tally_step: assert property (@(posedge clk_in) disable iff (reset_in)
    (tx_err_in && !bus_off_q) |=> tally_q == $past(tally_q) + 8'h01)
    else $error("tally did not count error");
  chk_recover_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    recovered |=> tally_q == 8'h00 && !bus_off_q) else $error("recovery did not clear");
  sequence s_done_ok;
    busy_q && tx_done_in && tx_ok_in;
  endsequence
  chk_req_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    s_done_ok |=> !con_q[$past(cur_q)][txbuf_pkg::BIT_REQ]) else $error("request stuck");
  chk_locked_body: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_buf && locked && ofs == txbuf_pkg::OFS_LEN) |=> len_q[$past(sel)] == $past(len_q[sel]))
    else $error("locked buffer written");
  chk_locked_data: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_buf && locked && is_data) |=>
      data_q[$past(sel)][$past(didx)] == $past(data_q[sel][didx]))
    else $error("locked data byte written");
  chk_rtr_copy: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_frame_out.remote == len_q[cur_q][txbuf_pkg::BIT_RTR]) else $error("remote flag");
endmodule
`default_nettype wire

/* src/txbuf_pkg.sv */
// Package: register map, field layout and constants of the transmit buffer store
// ---------------------------------------------------------------------------
// Summary of operation
// - Extended id bytes ignored for standard frames
// - Eight data byte registers per buffer
// - Length codes 0..8 valid, above reserved
// - Remote flag copied into sent frame
// - Eight-bit error tally, read-only, reset zero
// - Tally overflow enters bus-off state
// - 128 runs of 11 recessive clear tally
// - Send only in normal or loopback mode
// - Window field 1000 maps buffer zero on receive zero
// - Request self-clears on success; buffer read-only meanwhile except its control register
// - Extended enable selects 29 or 11 bit id
// ---------------------------------------------------------------------------
`default_nettype none
package txbuf_pkg;
  // ---------------------------------------------------------------------------
  // Address map: bits 7:4 select a page, bits 3:0 the register
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PAGE_BUF0   = 8'h00;
  localparam logic [7:0] PAGE_BUF1   = 8'h10;
  localparam logic [7:0] PAGE_BUF2   = 8'h20;
  localparam logic [7:0] PAGE_RX_ZERO = 8'h30;
  localparam logic [3:0] OFS_CON     = 4'h0;
  localparam logic [3:0] OFS_SIDH    = 4'h1;
  localparam logic [3:0] OFS_SIDL    = 4'h2;
  localparam logic [3:0] OFS_EIDH    = 4'h3;
  localparam logic [3:0] OFS_EIDL    = 4'h4;
  localparam logic [3:0] OFS_LEN     = 4'h5;
  localparam logic [3:0] OFS_DATA0   = 4'h8;
  localparam logic [7:0] ADDR_CTRL   = 8'h40;
  localparam logic [7:0] ADDR_TALLY  = 8'h41;
  localparam logic [7:0] ADDR_STAT   = 8'h42;
  localparam logic [7:0] ADDR_MASK   = 8'h43;
  // ---------------------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------------------
  localparam int         BIT_REQ     = 3;
  localparam int         BIT_EXT_EN  = 3;
  localparam int         BIT_RTR     = 6;
  localparam logic [3:0] WINDOW_BUF0 = 4'h8;
  localparam logic [3:0] LEN_MAX     = 4'h8;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_LOOP   = 3'h2;
  localparam logic [7:0] CON_WMASK   = 8'h0B;
  localparam logic [7:0] SIDL_WMASK  = 8'hEB;
  localparam logic [7:0] LEN_WMASK   = 8'h4F;
  localparam int         RUN_BITS    = 11;
  localparam int         RUN_COUNT   = 128;
  localparam int         NUM_IRQ     = 3;
  localparam logic [7:0] ZERO8       = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Frame handed to the bit engine
  typedef struct packed {
    logic        extended;
    logic [28:0] ident;
    logic        remote;
    logic [3:0]  length;
    logic [63:0] data;
  } frame_t;
endpackage
`default_nettype wire

/* tb/can_bus_node_model.sv */
// Far-side node model: completes each started frame after a fixed delay
`default_nettype none
module can_bus_node_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       err_in,
  output var  logic       done_out,
  output var  logic       ok_out,
  output var  logic       err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] wait_q = 9'h000;
  // One error pulse per cycle that err_in is held, so counts stay exact
  always @(posedge clk_in) begin
    err_out  <= err_in && !reset_in;
    done_out <= (wait_q == 9'h001);
    ok_out   <= (wait_q == 9'h001);
    if (reset_in)
      wait_q <= 9'h000;
    else if (start_in)
      wait_q <= {1'b0, delay_in} + 9'h001;
    else if (wait_q != 9'h000)
      wait_q <= wait_q - 9'h001;
  end
endmodule
`default_nettype wire

/* tb/can_tx_buffer_message_store_test.sv */
// Self-checking bench of the transmit buffer store
`default_nettype none
module can_tx_buffer_message_store_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk_in = 1'b0;
  logic                reset_in = 1'b1;
  logic                err_q = 1'b0;
  logic                rec_q = 1'b0;
  txbuf_pkg::reg_req_t bus = '0;
  txbuf_pkg::frame_t   frame;
  logic [7:0]          rdata;
  logic [7:0]          rd_v;
  logic [1:0]          tbuf;
  logic                start, done, ok, terr, boff, irq;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  starts = 0;
  int                  n;
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) if (start === 1'b1) starts <= starts + 1;
  can_tx_buffer_message_store uut (.clk_in(clk_in), .reset_in(reset_in), .bus_in(bus),
    .rdata_out(rdata), .tx_start_out(start), .tx_frame_out(frame), .tx_buf_out(tbuf),
    .tx_done_in(done), .tx_err_in(terr), .tx_ok_in(ok), .recessive_bit_in(rec_q),
    .bus_off_out(boff), .irq_out(irq));
  can_bus_node_model node (.clk_in(clk_in), .reset_in(reset_in), .start_in(start),
    .delay_in(8'h06), .err_in(err_q), .done_out(done), .ok_out(ok), .err_out(terr));
  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rd_v);
    check(rd_v, exp);
  endtask
  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask
  // Holds one pulse source for exactly k sampled edges
  task automatic burst(input bit e, input int k);
    @(posedge clk_in) if (e) err_q <= 1'b1; else rec_q <= 1'b1;
    repeat (k) @(posedge clk_in);
    err_q <= 1'b0;
    rec_q <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic poll(input logic [7:0] a);
    n = 0;
    do begin
      rd(a, rd_v);
      n++;
    end while (rd_v[3] === 1'b1 && n < 40);
    check(rd_v, 8'h00);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rchk(8'h41, 8'h00);
    wr(8'h41, 8'h55);
    burst(1'b1, 3);
    rchk(8'h41, 8'h03);
    wr(8'h40, 8'h20);
    for (int i = 0; i < 8; i++) wr(8'h08 + 8'(i), 8'hA0 + 8'(i));
    wr(8'h01, 8'h24);
    wr(8'h02, 8'h60);
    wr(8'h03, 8'h11);
    wr(8'h05, 8'h43);
    settle();
    check(frame.extended, 1'b0);
    check(frame.remote, 1'b1);
    check(frame.length, 4'h3);
    check(frame.data, 64'hA7A6A5A4A3A2A1A0);
    wr(8'h03, 8'hEE);
    wr(8'h04, 8'h22);
    settle();
    check(frame.ident, {18'h00000, 8'h24, 3'h3});
    wr(8'h02, 8'h68);
    settle();
    check(frame.ident, {8'h24, 3'h3, 2'h0, 8'hEE, 8'h22});
    wr(8'h05, 8'h0F);
    settle();
    check(frame.length, 4'h8);
    wr(8'h05, 8'h43);
    wr(8'h00, 8'h08);
    repeat (20) @(posedge clk_in);
    check(starts, 0);
    wr(8'h08, 8'h5A);
    rchk(8'h08, 8'hA0);
    wr(8'h05, 8'h01);
    rchk(8'h05, 8'h43);
    wr(8'h43, 8'h01);
    wr(8'h40, 8'h00);
    poll(8'h00);
    check(starts, 1);
    check(irq, 1'b1);
    wr(8'h42, 8'h01);
    settle();
    check(irq, 1'b0);
    wr(8'h40, 8'h40);
    wr(8'h10, 8'h08);
    poll(8'h10);
    check({starts[1:0], tbuf}, 4'h9);
    rchk(8'h41, 8'h01);
    wr(8'h40, 8'h08);
    wr(8'h38, 8'h77);
    rchk(8'h08, 8'h77);
    rchk(8'h31, 8'h24);
    wr(8'h40, 8'h00);
    rchk(8'h38, 8'h00);
    rchk(8'h50, 8'h00);
    burst(1'b1, 254);
    check({boff, rdata}, 9'h000);
    rchk(8'h41, 8'hFF);
    burst(1'b1, 1);
    check(boff, 1'b1);
    rchk(8'h41, 8'h00);
    rd(8'h42, rd_v);
    check(rd_v[2], 1'b1);
    wr(8'h20, 8'h08);
    repeat (20) @(posedge clk_in);
    check(starts, 2);
    burst(1'b0, 1397);
    check(boff, 1'b1);
    burst(1'b0, 11);
    check(boff, 1'b0);
    rchk(8'h41, 8'h00);
    poll(8'h20);
    check(starts, 3);
    final_report();
  end
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
